// *** rtl/rvi_pkg.sv ***
// Constants shared by the RGB video input port
package rvi_pkg;

   // ---------------------------------------------------------------
   // Register offsets of the command interface
   // ---------------------------------------------------------------
   localparam logic [7:0] PIXEL_FORMAT_SETTING_OFS = 8'h17;
   localparam logic [7:0] RGB_MODE_SELECT_OFS = 8'h31;
   localparam logic [7:0] RGB_SIGNAL_POLARITY_OFS = 8'h32;
   localparam logic [7:0] HORIZONTAL_PORCH_LOW_OFS = 8'h33;
   localparam logic [7:0] PORCH_CONTROL_OFS = 8'h34;

   // ---------------------------------------------------------------
   // Pixel format codes
   // ---------------------------------------------------------------
   localparam logic [7:0] FMT_565 = 8'h50;
   localparam logic [7:0] FMT_666 = 8'h60;
   localparam logic [7:0] FMT_SERIAL6 = 8'he0;

   // ---------------------------------------------------------------
   // Mode select codes
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_DE = 2'h2;
   localparam logic [1:0] MODE_PORCH = 2'h3;

   // ---------------------------------------------------------------
   // Polarity register bit positions
   // ---------------------------------------------------------------
   localparam int POL_DATA_ENABLE = 0;
   localparam int POL_FRAME_SYNC = 1;
   localparam int POL_LINE_SYNC = 2;
   localparam int POL_PIXCLK_EDGE = 3;

   // ---------------------------------------------------------------
   // Bus field positions
   // ---------------------------------------------------------------
   localparam int RED_MSB = 17;
   localparam int RED_LSB = 12;
   localparam int RED5_LSB = 13;
   localparam int GREEN_MSB = 11;
   localparam int GREEN_LSB = 6;
   localparam int BLUE_MSB = 5;
   localparam int BLUE_LSB = 0;
   localparam int BLUE5_LSB = 1;
   localparam int SER_MSB = 7;
   localparam int SER_LSB = 2;

   // ---------------------------------------------------------------
   // Serial colour phases
   // ---------------------------------------------------------------
   localparam logic [1:0] PHASE_RED = 2'h0;
   localparam logic [1:0] PHASE_GREEN = 2'h1;
   localparam logic [1:0] PHASE_BLUE = 2'h2;

   // Receiver states, Gray along idle, wait, active
   typedef enum logic [1:0] {
      RVI_IDLE = 2'b00,
      RVI_WAIT_FRAME = 2'b01,
      RVI_ACTIVE = 2'b11
   } rvi_state_type;

endpackage

// *** rtl/rvi_rgb_video_input_port.sv ***
// Receiver for the parallel RGB video input port
//
// Operation
// - Mode select 10 uses data enable mode.
// - Mode select 11 ignores data enable pin.
// - Interface active only after power-on done.
// - Sample syncs, enable, data on clock edge.
// - Mode 1 takes pixel when enable high.
// - Mode 2 picks pixels from back porches.
// - Pixels go straight out, no memory.
// - Frame sync active low restarts frame.
// - Line sync active low restarts line.
// - Data enable active high marks pixels.
// - Recover automatically at next frame sync.
// - Format 50h takes 5-6-5 pixel.
// - Format 60h takes 6-6-6 pixel.
// - Format E0h takes three six-bit transfers.
// - Mode 2 porches from registers, no enable.
// - Components are binary intensity, ones full.
// - Six-bit transfer: bit 7 is MSB.
module rvi_rgb_video_input_port #(
   parameter int DATA_WIDTH = 18,
   parameter int HBP_WIDTH = 10,
   parameter int VBP_WIDTH = 6,
   parameter int COUNT_WIDTH = 11
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic powerOnDone,
   input wire logic [7:0] pixelFormatSetting,
   input wire logic [1:0] rgbModeSel,
   input wire logic [3:0] rgbSignalPolarity,
   input wire logic [HBP_WIDTH-1:0] horizontalBackPorch,
   input wire logic [VBP_WIDTH-1:0] verticalBackPorch,
   input wire logic pixelClock,
   input wire logic frameSync_b,
   input wire logic lineSync_b,
   input wire logic dataEnable,
   input wire logic [DATA_WIDTH-1:0] videoDataBus,
   output logic pixelValid,
   output logic [5:0] pixelRed,
   output logic [5:0] pixelGreen,
   output logic [5:0] pixelBlue,
   output logic frameStart,
   output logic lineStart,
   output logic interfaceActive
);

   localparam int PIN_WIDTH = DATA_WIDTH + 4;
   localparam logic [COUNT_WIDTH-1:0] CNT_ONE = COUNT_WIDTH'(1);
   localparam logic [COUNT_WIDTH-1:0] CNT_MAX = '1;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [PIN_WIDTH-1:0] pinMeta_q, pinMeta_d;
   logic [PIN_WIDTH-1:0] pinSync_q, pinSync_d;

   always_comb begin
      pinMeta_d = {pixelClock, frameSync_b, lineSync_b, dataEnable,
                   videoDataBus};
      pinSync_d = pinMeta_q;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pinMeta_q <= '0;
         pinSync_q <= '0;
      end else begin
         pinMeta_q <= pinMeta_d;
         pinSync_q <= pinSync_d;
      end
   end

   logic clkS, frameS_b, lineS_b, enableS;
   logic [DATA_WIDTH-1:0] dataS;
   assign {clkS, frameS_b, lineS_b, enableS, dataS} = pinSync_q;

   // ---------------------------------------------------------------
   // Edge finding and active levels
   // ---------------------------------------------------------------
   logic clkPrev_q, clkPrev_d;
   logic frameActPrev_q, frameActPrev_d;
   logic lineActPrev_q, lineActPrev_d;
   logic sampleEdge, frameAct, lineAct, enableAct;
   logic frameEdge, lineEdge;

   always_comb begin
      // Sampling edge choice, rising by default
      if (rgbSignalPolarity[rvi_pkg::POL_PIXCLK_EDGE]) begin
         sampleEdge = clkPrev_q & ~clkS;
      end else begin
         sampleEdge = clkS & ~clkPrev_q;
      end
      // Syncs low active, enable high active by default
      frameAct = rgbSignalPolarity[rvi_pkg::POL_FRAME_SYNC] ?
                 frameS_b : ~frameS_b;
      lineAct = rgbSignalPolarity[rvi_pkg::POL_LINE_SYNC] ?
                lineS_b : ~lineS_b;
      enableAct = rgbSignalPolarity[rvi_pkg::POL_DATA_ENABLE] ?
                  ~enableS : enableS;
      frameEdge = sampleEdge & frameAct & ~frameActPrev_q;
      lineEdge = sampleEdge & lineAct & ~lineActPrev_q;
      clkPrev_d = clkS;
      frameActPrev_d = sampleEdge ? frameAct : frameActPrev_q;
      lineActPrev_d = sampleEdge ? lineAct : lineActPrev_q;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         clkPrev_q <= 1'b0;
         frameActPrev_q <= 1'b0;
         lineActPrev_q <= 1'b0;
      end else begin
         clkPrev_q <= clkPrev_d;
         frameActPrev_q <= frameActPrev_d;
         lineActPrev_q <= lineActPrev_d;
      end
   end

   // ---------------------------------------------------------------
   // Receiver state
   // ---------------------------------------------------------------
   rvi_pkg::rvi_state_type state_q, state_d;
   logic enable, fmtValid;

   always_comb begin
      // Only mode codes 10 and 11 select the video port
      enable = powerOnDone && ((rgbModeSel == rvi_pkg::MODE_DE) ||
                               (rgbModeSel == rvi_pkg::MODE_PORCH));
      fmtValid = (pixelFormatSetting == rvi_pkg::FMT_565) ||
                 (pixelFormatSetting == rvi_pkg::FMT_666) ||
                 (pixelFormatSetting == rvi_pkg::FMT_SERIAL6);
      state_d = state_q;
      case (state_q)
         rvi_pkg::RVI_IDLE: begin
            if (enable) begin
               state_d = rvi_pkg::RVI_WAIT_FRAME;
            end
         end
         rvi_pkg::RVI_WAIT_FRAME: begin
            if (!enable) begin
               state_d = rvi_pkg::RVI_IDLE;
            end else if (frameEdge) begin
               state_d = rvi_pkg::RVI_ACTIVE;
            end
         end
         rvi_pkg::RVI_ACTIVE: begin
            if (!enable) begin
               state_d = rvi_pkg::RVI_IDLE;
            end
         end
         default: begin
            state_d = rvi_pkg::RVI_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_q <= rvi_pkg::RVI_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ---------------------------------------------------------------
   // Line and column counters
   // ---------------------------------------------------------------
   logic [COUNT_WIDTH-1:0] colCount_q, colCount_d;
   logic [COUNT_WIDTH-1:0] lineCount_q, lineCount_d;
   logic porchOk, accept;

   always_comb begin
      colCount_d = colCount_q;
      lineCount_d = lineCount_q;
      if (sampleEdge) begin
         if (lineEdge || frameEdge) begin
            colCount_d = '0;
         end else if (colCount_q != CNT_MAX) begin
            colCount_d = colCount_q + CNT_ONE;
         end
         if (frameEdge) begin
            lineCount_d = '0;
         end else if (lineEdge && lineCount_q != CNT_MAX) begin
            lineCount_d = lineCount_q + CNT_ONE;
         end
      end
      // Porch window from register values, enable pin unused
      porchOk = (colCount_d >= COUNT_WIDTH'(horizontalBackPorch)) &&
                (lineCount_d >= COUNT_WIDTH'(verticalBackPorch)) &&
                !lineAct && !frameAct;
      accept = (state_q == rvi_pkg::RVI_ACTIVE) && sampleEdge &&
               fmtValid && enable &&
               ((rgbModeSel == rvi_pkg::MODE_DE) ? enableAct :
                porchOk);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         colCount_q <= '0;
         lineCount_q <= '0;
      end else begin
         colCount_q <= colCount_d;
         lineCount_q <= lineCount_d;
      end
   end

   // ---------------------------------------------------------------
   // Pixel assembly, direct to the display path
   // ---------------------------------------------------------------
   logic [1:0] phase_q, phase_d;
   logic [5:0] heldRed_q, heldRed_d;
   logic [5:0] heldGreen_q, heldGreen_d;
   logic pixelValid_q, pixelValid_d;
   logic [5:0] red_q, red_d, green_q, green_d, blue_q, blue_d;
   logic frameStart_q, frameStart_d, lineStart_q, lineStart_d;
   logic [5:0] serialComp;

   always_comb begin
      serialComp = dataS[rvi_pkg::SER_MSB:rvi_pkg::SER_LSB];
      phase_d = phase_q;
      heldRed_d = heldRed_q;
      heldGreen_d = heldGreen_q;
      pixelValid_d = 1'b0;
      red_d = red_q;
      green_d = green_q;
      blue_d = blue_q;
      frameStart_d = (state_q == rvi_pkg::RVI_ACTIVE) && frameEdge;
      lineStart_d = (state_q == rvi_pkg::RVI_ACTIVE) && lineEdge;
      if (lineEdge || frameEdge || state_q != rvi_pkg::RVI_ACTIVE) begin
         phase_d = rvi_pkg::PHASE_RED;
      end else if (accept) begin
         // Six-bit components pass unchanged, 5-bit red and blue append their MSB: zero is none, ones full
         case (pixelFormatSetting)
            rvi_pkg::FMT_565: begin
               pixelValid_d = 1'b1;
               red_d = {dataS[rvi_pkg::RED_MSB:rvi_pkg::RED5_LSB],
                        dataS[rvi_pkg::RED_MSB]};
               green_d = dataS[rvi_pkg::GREEN_MSB:rvi_pkg::GREEN_LSB];
               blue_d = {dataS[rvi_pkg::BLUE_MSB:rvi_pkg::BLUE5_LSB],
                         dataS[rvi_pkg::BLUE_MSB]};
            end
            rvi_pkg::FMT_666: begin
               pixelValid_d = 1'b1;
               red_d = dataS[rvi_pkg::RED_MSB:rvi_pkg::RED_LSB];
               green_d = dataS[rvi_pkg::GREEN_MSB:rvi_pkg::GREEN_LSB];
               blue_d = dataS[rvi_pkg::BLUE_MSB:rvi_pkg::BLUE_LSB];
            end
            default: begin
               // Red, green, blue over three transfers
               case (phase_q)
                  rvi_pkg::PHASE_RED: begin
                     heldRed_d = serialComp;
                     phase_d = rvi_pkg::PHASE_GREEN;
                  end
                  rvi_pkg::PHASE_GREEN: begin
                     heldGreen_d = serialComp;
                     phase_d = rvi_pkg::PHASE_BLUE;
                  end
                  default: begin
                     pixelValid_d = 1'b1;
                     red_d = heldRed_q;
                     green_d = heldGreen_q;
                     blue_d = serialComp;
                     phase_d = rvi_pkg::PHASE_RED;
                  end
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         phase_q <= rvi_pkg::PHASE_RED;
         heldRed_q <= '0;
         heldGreen_q <= '0;
         pixelValid_q <= 1'b0;
         red_q <= '0;
         green_q <= '0;
         blue_q <= '0;
         frameStart_q <= 1'b0;
         lineStart_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         heldRed_q <= heldRed_d;
         heldGreen_q <= heldGreen_d;
         pixelValid_q <= pixelValid_d;
         red_q <= red_d;
         green_q <= green_d;
         blue_q <= blue_d;
         frameStart_q <= frameStart_d;
         lineStart_q <= lineStart_d;
      end
   end

   assign pixelValid = pixelValid_q;
   assign pixelRed = red_q;
   assign pixelGreen = green_q;
   assign pixelBlue = blue_q;
   assign frameStart = frameStart_q;
   assign lineStart = lineStart_q;
   assign interfaceActive = (state_q == rvi_pkg::RVI_ACTIVE);

endmodule

// *** tb/rvi_port_assertions.sv ***
// Assertion checker bound to the RGB video input port
module rvi_port_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic powerOnDone,
   input wire logic [7:0] pixelFormatSetting,
   input wire logic [1:0] rgbModeSel,
   input wire logic [3:0] rgbSignalPolarity,
   input wire logic frameSync_b,
   input wire logic lineSync_b,
   input wire logic dataEnable,
   input wire logic [17:0] videoDataBus,
   input wire logic pixelValid,
   input wire logic [5:0] pixelRed,
   input wire logic [5:0] pixelGreen,
   input wire logic [5:0] pixelBlue,
   input wire logic frameStart,
   input wire logic lineStart,
   input wire logic interfaceActive
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------
   // Pin activity and properties
   // ------------------------------
   logic fsAct;
   logic lsAct;
   logic deAct;
   assign fsAct = frameSync_b == rgbSignalPolarity[1];
   assign lsAct = lineSync_b == rgbSignalPolarity[2];
   assign deAct = dataEnable != rgbSignalPolarity[0];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_fs_seen;
      $past(fsAct, 2);
   endsequence
   sequence s_ls_seen;
      $past(lsAct, 2);
   endsequence
   a_pix_active: assert property (
      pixelValid |-> $past(interfaceActive))
      else $error("pixel outside active state");
   a_power_drop: assert property (
      !powerOnDone |=> !interfaceActive)
      else $error("active without power on");
   a_mode_off: assert property (
      !rgbModeSel[1] |=> !interfaceActive)
      else $error("active with port disabled");
   a_pulse_single: assert property (
      pixelValid |=> !pixelValid)
      else $error("pixel pulse too long");
   a_colour_hold: assert property (
      !pixelValid |-> $stable({pixelRed, pixelGreen, pixelBlue}))
      else $error("colour changed without pixel");
   a_frame_cause: assert property (
      frameStart |-> s_fs_seen)
      else $error("frame start without frame sync");
   a_line_cause: assert property (
      lineStart |-> s_ls_seen)
      else $error("line start without line sync");
   a_enable_gate: assert property (
      pixelValid && rgbModeSel == rvi_pkg::MODE_DE |-> $past(deAct, 2))
      else $error("pixel without data enable");
   a_porch_nosync: assert property (
      pixelValid && rgbModeSel == rvi_pkg::MODE_PORCH
      |-> !$past(fsAct, 2) && !$past(lsAct, 2))
      else $error("pixel on sync sample");
   a_full_fields: assert property (
      pixelValid && pixelFormatSetting == rvi_pkg::FMT_666
      |-> {pixelRed, pixelGreen, pixelBlue} == $past(videoDataBus, 2))
      else $error("666 fields wrong");
   a_short_fields: assert property (
      pixelValid && pixelFormatSetting == rvi_pkg::FMT_565
      |-> pixelRed[5:1] == $past(videoDataBus[17:13], 2)
      && pixelBlue[5:1] == $past(videoDataBus[5:1], 2)
      && pixelRed[0] == pixelRed[5] && pixelBlue[0] == pixelBlue[5])
      else $error("565 fields wrong");
endmodule

bind rvi_rgb_video_input_port rvi_port_checker u_rvi_chk (
   .core_clk, .rst_b, .powerOnDone, .pixelFormatSetting, .rgbModeSel,
   .rgbSignalPolarity, .frameSync_b, .lineSync_b, .dataEnable,
   .videoDataBus, .pixelValid, .pixelRed, .pixelGreen, .pixelBlue,
   .frameStart, .lineStart, .interfaceActive
);

// *** tb/rvi_host_model.sv ***
// Host controller model driving the RGB video pins
module rvi_host_model (
   input wire logic edgeInv,
   input wire logic reqFs_b,
   input wire logic reqLs_b,
   input wire logic reqDe,
   input wire logic [17:0] reqData,
   output logic pixelClock,
   output logic frameSync_b,
   output logic lineSync_b,
   output logic dataEnable,
   output logic [17:0] videoDataBus,
   output logic slot
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------
   // Free running clock, pin launch
   // ------------------------------
   initial begin
      pixelClock = 1'b0;
      frameSync_b = 1'b1;
      lineSync_b = 1'b1;
      dataEnable = 1'b0;
      videoDataBus = 18'h00000;
      slot = 1'b0;
      #7;
      forever begin
         #80 pixelClock = ~pixelClock;
         // Pins move on the edge opposite to sampling
         if (pixelClock == edgeInv) begin
            frameSync_b = reqFs_b;
            lineSync_b = reqLs_b;
            dataEnable = reqDe;
            videoDataBus = reqData;
            slot = ~slot;
         end
      end
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking testbench of the RGB video input port
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------
   // Signals, models and tasks
   // ------------------------------
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic powerOnDone = 1'b0;
   logic [7:0] fmt = 8'h60;
   logic [1:0] mode = 2'h2;
   logic [3:0] pol = 4'h0;
   logic [9:0] horizontal_back_porch = 10'h000;
   logic [5:0] vertical_back_porch = 6'h00;
   logic fsReq_b = 1'b1;
   logic lsReq_b = 1'b1;
   logic deReq = 1'b0;
   logic [17:0] dReq = 18'h00000;
   logic pixelClock, frameSync_b, lineSync_b, dataEnable, slot;
   logic [17:0] videoDataBus;
   logic pixelValid, frameStart, lineStart, interfaceActive;
   logic [5:0] pixelRed, pixelGreen, pixelBlue;
   logic [17:0] gotQ[$];
   logic [17:0] expQ[$];
   logic [17:0] part = 18'h00000;
   logic [31:0] seed = 32'h9017;
   logic ok = 1'b0;
   logic armed = 1'b0;
   int error_cnt = 0;
   int tests_run = 0;
   int fsCnt = 0;
   int lsCnt = 0;
   int col = 0;
   int row = 0;
   int phase = 0;
   always #10 core_clk = ~core_clk;
   rvi_rgb_video_input_port dut (.core_clk, .rst_b, .powerOnDone,
      .pixelFormatSetting(fmt), .rgbModeSel(mode), .rgbSignalPolarity(pol),
      .horizontalBackPorch(horizontal_back_porch), .verticalBackPorch(vertical_back_porch), .pixelClock,
      .frameSync_b, .lineSync_b, .dataEnable, .videoDataBus, .pixelValid,
      .pixelRed, .pixelGreen, .pixelBlue, .frameStart, .lineStart,
      .interfaceActive);
   rvi_host_model host (.edgeInv(pol[3]), .reqFs_b(fsReq_b),
      .reqLs_b(lsReq_b), .reqDe(deReq), .reqData(dReq), .pixelClock,
      .frameSync_b, .lineSync_b, .dataEnable, .videoDataBus, .slot);
   always @(posedge core_clk) begin
      if (pixelValid === 1'b1)
         gotQ.push_back({pixelRed, pixelGreen, pixelBlue});
      if (frameStart === 1'b1)
         fsCnt++;
      if (lineStart === 1'b1)
         lsCnt++;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction
   function automatic logic [17:0] expPix(input logic [17:0] d);
      if (fmt == rvi_pkg::FMT_565)
         return {d[17:13], d[17], d[11:6], d[5:1], d[5]};
      return d;
   endfunction
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkFlag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   // One pixel clock sample, with the expected outcome
   task automatic xfer(input bit fs, input bit ls, input bit de,
         input logic [17:0] d);
      bit take;
      @(posedge core_clk);
      fsReq_b <= fs ~^ pol[1];
      lsReq_b <= ls ~^ pol[2];
      deReq <= de ^ pol[0];
      dReq <= d;
      @(slot);
      take = 1'b0;
      if (fs || ls) begin
         col = 0;
         phase = 0;
         row = fs ? 0 : row + 1;
         armed = armed | (fs & ok);
      end else begin
         col++;
         take = mode == rvi_pkg::MODE_DE ? de : col >= horizontal_back_porch && row >= vertical_back_porch;
      end
      if (take && armed && fmt != rvi_pkg::FMT_SERIAL6)
         expQ.push_back(expPix(d));
      else if (take && armed) begin
         part = {part[11:0], d[7:2]};
         if (phase == 2)
            expQ.push_back(part);
         phase = (phase + 1) % 3;
      end
   endtask
   task automatic run(input logic [7:0] f, input logic [1:0] m,
         input logic [3:0] p, input int lines, input int n, input string nm);
      int fs0;
      int ls0;
      @(posedge core_clk);
      fs0 = fsCnt;
      ls0 = lsCnt;
      powerOnDone <= 1'b0;
      repeat (2) xfer(0, 0, 0, 18'h00000);
      @(posedge core_clk);
      fmt <= f;
      mode <= m;
      pol <= p;
      armed = 1'b0;
      ok = m[1] && (f == 8'h50 || f == 8'h60 || f == 8'he0);
      repeat (2) xfer(0, 0, 0, 18'h00000);
      @(posedge core_clk);
      powerOnDone <= 1'b1;
      xfer(0, 0, 0, 18'h00000);
      xfer(1, 0, 0, 18'h00000);
      for (int i = 0; i < lines; i++) begin
         xfer(0, 1, 0, 18'h00000);
         for (int j = 0; j < n; j++) begin
            seed = lfsr(seed);
            xfer(0, 0, j < 2 || seed[20], j == 0 ? 18'h3ffff :
               j == 1 ? 18'h00000 : seed[17:0]);
         end
      end
      // Second frame sync while active must restart the frame
      xfer(1, 0, 0, 18'h00000);
      repeat (12) @(posedge core_clk);
      chkFlag(interfaceActive, m[1]);
      chk(18'(fsCnt - fs0), m[1] ? 18'h00001 : 18'h00000);
      chk(18'(lsCnt - ls0), m[1] ? 18'(lines) : 18'h00000);
      chk(18'(gotQ.size()), 18'(expQ.size()));
      while (gotQ.size() > 0 && expQ.size() > 0)
         chk(gotQ.pop_front(), expQ.pop_front());
      gotQ.delete();
      expQ.delete();
      $display("test %s done", nm);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Whole run is near 42 us; allow several times that
   initial begin
      #500000;
      error_cnt++;
      $display("ERROR %0t watchdog expired", $time);
      stop_test;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      chk({pixelRed, pixelGreen, pixelBlue}, 18'h00000);
      chkFlag(interfaceActive, 1'b0);
      run(8'h60, 2'h2, 4'h0, 3, 9, "mode1_666");
      run(8'h50, 2'h2, 4'h0, 2, 8, "mode1_565");
      run(8'he0, 2'h2, 4'h0, 3, 10, "mode1_six");
      horizontal_back_porch <= 10'h003;
      vertical_back_porch <= 6'h01;
      run(8'h60, 2'h3, 4'h0, 3, 8, "mode2_porch");
      run(8'he0, 2'h3, 4'hf, 2, 9, "mode2_invert");
      run(8'h50, 2'h2, 4'ha, 2, 7, "mode1_invert");
      run(8'h70, 2'h2, 4'h0, 2, 6, "bad_format");
      run(8'h60, 2'h0, 4'h0, 2, 6, "port_off");
      run(8'h60, 2'h2, 4'h0, 2, 6, "recover");
      stop_test;
   end
endmodule
